// >>> pkg/eprom_eprom_program_control_pkg.sv
// Constants shared by the EPROM byte programming control block
package eprom_pgm_pkg;

   // ********************************************************
   // Register map
   // ********************************************************
   localparam int          REG_AW       = 8;
   localparam int          REG_DW       = 8;
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  STAT_OFS     = 8'h01;

   // ********************************************************
   // Field positions and reset values
   // ********************************************************
   localparam int          LATCH_BIT     = 2;
   localparam int          VPP_BIT       = 0;
   localparam int          STAT_HELD_BIT = 0;
   localparam int          STAT_DONE_BIT = 1;
   localparam logic [7:0]  CTRL_RST      = 8'h00;

   // ********************************************************
   // Timing
   // ********************************************************
   localparam int          CLK_KHZ        = 40000;
   localparam int          PULSE_TIME_US  = 1000;
   // Least time, so round up to whole cycles
   localparam int          PULSE_CYC      = (PULSE_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int          EP_AW          = 14;
   localparam int          CNT_W          = 18;

endpackage

// >>> pkg/eprom_latch_if.sv
// Carrier between the control register logic and the address/data latch
`timescale 1ns/1ps
`default_nettype none

interface eprom_latch_if
#(
   parameter int AW = 14
);
   logic          arm;
   logic          cpu_wr;
   logic [AW-1:0] cpu_addr;
   logic [7:0]    cpu_data;
   logic          held;
   logic [AW-1:0] held_addr;
   logic [7:0]    held_data;

   modport ctrl
   (
      output arm,
      output cpu_wr,
      output cpu_addr,
      output cpu_data,
      input  held,
      input  held_addr,
      input  held_data
   );

   modport hold
   (
      input  arm,
      input  cpu_wr,
      input  cpu_addr,
      input  cpu_data,
      output held,
      output held_addr,
      output held_data
   );
endinterface

`default_nettype wire

// >>> rtl/eprom_byte_program_control.sv
// Control register and path steering for programming single EPROM bytes
`timescale 1ns/1ps
`default_nettype none

module eprom_byte_program_control
#(
   parameter int EP_AW     = eprom_pgm_pkg::EP_AW,
   parameter int CNT_W     = eprom_pgm_pkg::CNT_W,
   parameter int PULSE_CYC = eprom_pgm_pkg::PULSE_CYC
)
(
   // Clock and reset
   input  wire logic                             sys_clk_in,
   input  wire logic                             sys_rst_in,
   // Register port
   input  wire logic [eprom_pgm_pkg::REG_AW-1:0] reg_addr_in,
   input  wire logic [eprom_pgm_pkg::REG_DW-1:0] reg_wdata_in,
   input  wire logic                             reg_wr_in,
   input  wire logic                             reg_rd_in,
   output logic [eprom_pgm_pkg::REG_DW-1:0]      reg_rdata_out,
   // CPU access to the EPROM space
   input  wire logic [EP_AW-1:0]                 cpu_addr_in,
   input  wire logic [7:0]                       cpu_wdata_in,
   input  wire logic                             cpu_wr_in,
   input  wire logic                             cpu_rd_in,
   output logic [7:0]                            cpu_rdata_out,
   // EPROM array
   output logic [EP_AW-1:0]                      array_addr_out,
   output logic [7:0]                            array_wdata_out,
   output logic                                  array_rd_en_out,
   input  wire logic [7:0]                       array_rdata_in,
   output logic                                  vpp_en_out
);
   import eprom_pgm_pkg::*;

   localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);

   typedef struct packed {
      logic             latch;
      logic             vpp;
      logic [CNT_W-1:0] cnt;
      logic             done;
      logic [7:0]       rdata;
      logic [7:0]       ep_rdata;
   } ctl_state_t;

   ctl_state_t st_r;
   ctl_state_t st_nxt;

   eprom_latch_if #(.AW(EP_AW)) lat ();

   logic ctrl_wr;
   logic ctrl_rd;
   logic stat_rd;
   logic want_latch;
   logic want_vpp;

   // ********************************************************
   // Address decode
   // ********************************************************
   assign ctrl_wr    = reg_wr_in && (reg_addr_in == CTRL_OFS);
   assign ctrl_rd    = reg_rd_in && (reg_addr_in == CTRL_OFS);
   assign stat_rd    = reg_rd_in && (reg_addr_in == STAT_OFS);
   assign want_latch = reg_wdata_in[LATCH_BIT];
   assign want_vpp   = reg_wdata_in[VPP_BIT];

   // ********************************************************
   // Next state
   // ********************************************************
   always_comb
   begin
      st_nxt = st_r;

      // Control register write; unused bits are simply not stored
      if (ctrl_wr)
      begin
         st_nxt.latch = want_latch;
         // Voltage needs a latch from an earlier write that stays set now
         st_nxt.vpp   = want_vpp && st_r.latch && want_latch;
      end

      // Pulse timer runs only under the voltage; it clears in the very cycle
      // the voltage drops, so a stale done flag never outlives the voltage
      if (!st_r.vpp || !st_nxt.vpp)
      begin
         st_nxt.cnt  = '0;
         st_nxt.done = 1'b0;
      end
      else if (st_r.cnt == PULSE_LAST)
      begin
         st_nxt.done = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end

      // Register read data stand in the cycle after the strobe only
      st_nxt.rdata = 8'h00;
      if (ctrl_rd)
      begin
         st_nxt.rdata[LATCH_BIT] = st_r.latch;
         st_nxt.rdata[VPP_BIT]   = st_r.vpp;
      end
      else if (stat_rd)
      begin
         st_nxt.rdata[STAT_HELD_BIT] = lat.held;
         st_nxt.rdata[STAT_DONE_BIT] = st_r.done;
      end

      // Array data reach the CPU only while not latched
      st_nxt.ep_rdata = 8'h00;
      if (cpu_rd_in && !st_r.latch)
      begin
         st_nxt.ep_rdata = array_rdata_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st_r       <= '0;
         st_r.latch <= CTRL_RST[LATCH_BIT];
         st_r.vpp   <= CTRL_RST[VPP_BIT];
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ********************************************************
   // Latch and array steering
   // ********************************************************
   assign lat.arm      = st_r.latch;
   assign lat.cpu_wr   = cpu_wr_in;
   assign lat.cpu_addr = cpu_addr_in;
   assign lat.cpu_data = cpu_wdata_in;

   eprom_write_latch #(.AW(EP_AW)) u_latch
   (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .lat        (lat)
   );

   // While latched the array sees the held location, not the CPU bus
   assign array_addr_out  = st_r.latch ? lat.held_addr : cpu_addr_in;
   assign array_wdata_out = lat.held_data;
   assign array_rd_en_out = cpu_rd_in && !st_r.latch;
   assign cpu_rdata_out   = st_r.ep_rdata;
   assign vpp_en_out      = st_r.vpp;
   assign reg_rdata_out   = st_r.rdata;

   // ********************************************************
   // Checks
   // ********************************************************
   AST_VPP_NEEDS_LATCH: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      vpp_en_out |-> st_r.latch)
      else $error("programming voltage without latch");

   AST_NO_DOUBLE_SET: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ctrl_wr && want_latch && want_vpp && !st_r.latch) |=> (st_r.latch && !vpp_en_out))
      else $error("latch and voltage set by one write");

   AST_VPP_SET: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ctrl_wr && want_latch && want_vpp && st_r.latch) |=> vpp_en_out)
      else $error("voltage not applied after valid set");

   AST_VPP_CLEAR: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ctrl_wr && !want_vpp) |=> !vpp_en_out)
      else $error("voltage stayed on after clear");

   AST_READ_BLOCKED: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      st_r.latch |-> (!array_rd_en_out ##1 cpu_rdata_out == 8'h00))
      else $error("array read while latched");

   AST_NORMAL_READ: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (cpu_rd_in && !st_r.latch) |->
         (array_rd_en_out && array_addr_out == cpu_addr_in
          ##1 cpu_rdata_out == $past(array_rdata_in)))
      else $error("ordinary read not routed");

   AST_CTRL_READBACK: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      ctrl_rd |=> (reg_rdata_out[LATCH_BIT] == $past(st_r.latch)
                   && reg_rdata_out[VPP_BIT] == $past(st_r.vpp)
                   && reg_rdata_out[7:3] == 5'h00 && !reg_rdata_out[1]))
      else $error("control readback wrong");

   AST_RDATA_ONE_CYCLE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data outside answer cycle");

   AST_PULSE_DONE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      st_r.done |-> (vpp_en_out && st_r.cnt == PULSE_LAST))
      else $error("pulse done without full voltage time");

   // ********************************************************
   // Register and path checks
   // ********************************************************
   AST_LATCH_WRITE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      ctrl_wr |=> (st_r.latch == $past(want_latch)))
      else $error("latch bit does not follow the write");

   AST_LATCH_KEEPS: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !ctrl_wr |=> $stable(st_r.latch))
      else $error("latch bit changed without a write");

   AST_VPP_KEEPS: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !ctrl_wr |=> $stable(vpp_en_out))
      else $error("voltage changed without a write");

   AST_VPP_REFUSED: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ctrl_wr && !st_r.latch) |=> !vpp_en_out)
      else $error("voltage set without an earlier latch");

   AST_LATCH_CLEAR_DROPS_VPP: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (ctrl_wr && !want_latch) |=> (!st_r.latch && !vpp_en_out))
      else $error("voltage kept after latch cleared");

   AST_ARRAY_HELD_PATH: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      st_r.latch |-> (array_addr_out == lat.held_addr && array_wdata_out == lat.held_data))
      else $error("array not fed from the held byte");

   AST_ARRAY_CPU_PATH: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !st_r.latch |-> (array_addr_out == cpu_addr_in))
      else $error("array address not from the cpu bus");

   AST_CPU_RDATA_IDLE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !$past(cpu_rd_in) |-> (cpu_rdata_out == 8'h00))
      else $error("cpu read data outside answer cycle");

   AST_STAT_READBACK: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      stat_rd |=> (reg_rdata_out[STAT_HELD_BIT] == $past(lat.held)
                   && reg_rdata_out[STAT_DONE_BIT] == $past(st_r.done)
                   && reg_rdata_out[7:2] == 6'h00))
      else $error("status readback wrong");

   AST_HELD_CLEARS: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !st_r.latch |=> !lat.held)
      else $error("held byte kept without latch");

   AST_UNMAPPED_READ: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (reg_rd_in && reg_addr_in != CTRL_OFS && reg_addr_in != STAT_OFS) |=>
         (reg_rdata_out == 8'h00))
      else $error("unmapped read returned data");

   AST_RD_EN_NORMAL: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !st_r.latch |-> (array_rd_en_out == cpu_rd_in))
      else $error("ordinary read enable not passed");

   // ********************************************************
   // Pulse timer checks
   // ********************************************************
   AST_CNT_IDLE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !vpp_en_out |-> (st_r.cnt == '0 && !st_r.done))
      else $error("pulse timer running without voltage");

   AST_CNT_STEP: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (vpp_en_out && !ctrl_wr && st_r.cnt != PULSE_LAST) |=>
         (st_r.cnt == $past(st_r.cnt) + CNT_W'(1)))
      else $error("pulse counter skipped a cycle");

   AST_DONE_AT_END: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (vpp_en_out && !ctrl_wr && st_r.cnt == PULSE_LAST) |=> st_r.done)
      else $error("pulse done not raised at end of count");

endmodule

`default_nettype wire

// >>> rtl/eprom_write_latch.sv
// Address and data latch that holds one EPROM write for programming
`timescale 1ns/1ps
`default_nettype none

module eprom_write_latch
#(
   parameter int AW = 14
)
(
   // Clock and reset
   input  wire logic   sys_clk_in,
   input  wire logic   sys_rst_in,
   // Towards the control logic
   eprom_latch_if.hold lat
);
   import eprom_pgm_pkg::*;

   typedef struct packed {
      logic          held;
      logic [AW-1:0] addr;
      logic [7:0]    data;
   } lat_state_t;

   lat_state_t st_r;
   lat_state_t st_nxt;

   // ********************************************************
   // Capture
   // ********************************************************
   // Only the first write after arming is kept; later writes cannot
   // disturb a byte that may already be under the programming voltage.
   always_comb
   begin
      st_nxt = st_r;
      if (!lat.arm)
      begin
         st_nxt.held = 1'b0;
      end
      else if (!st_r.held && lat.cpu_wr)
      begin
         st_nxt.held = 1'b1;
         st_nxt.addr = lat.cpu_addr;
         st_nxt.data = lat.cpu_data;
      end
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign lat.held      = st_r.held;
   assign lat.held_addr = st_r.addr;
   assign lat.held_data = st_r.data;

   AST_CAPTURE_FIRST_WRITE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (lat.arm && !st_r.held && lat.cpu_wr) |=>
         (st_r.held && st_r.addr == $past(lat.cpu_addr) && st_r.data == $past(lat.cpu_data)))
      else $error("armed write was not captured");

   AST_HELD_STABLE: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (st_r.held && lat.arm) |=> $stable(st_r.addr) && $stable(st_r.data))
      else $error("held byte changed while armed");

endmodule

`default_nettype wire

// >>> sim/eprom_byte_program_control_bench.sv
// Self-checking bench for the EPROM byte programming control block
`timescale 1ns/1ps
`default_nettype none

module eprom_byte_program_control_bench;
   import eprom_pgm_pkg::*;

   // *****
   // Stimulus and design
   // *****
   // Short pulse count keeps the run brief
   localparam int         PCYC = 8;
   localparam logic [7:0] LAT  = 8'(1 << LATCH_BIT);
   localparam logic [7:0] VPP  = 8'(1 << VPP_BIT);
   localparam logic [7:0] STAT = 8'(1 << STAT_HELD_BIT) | 8'(1 << STAT_DONE_BIT);

   logic             clk = 1'b0;
   logic             rst;
   logic [7:0]       r_addr;
   logic [7:0]       r_wdata;
   logic [7:0]       r_rdata;
   logic             r_wr;
   logic             r_rd;
   logic [EP_AW-1:0] c_addr;
   logic [EP_AW-1:0] a_addr;
   logic [7:0]       c_wdata;
   logic [7:0]       c_rdata;
   logic [7:0]       a_wdata;
   logic [7:0]       a_rdata;
   logic             c_wr;
   logic             c_rd;
   logic             a_rd_en;
   logic             vpp;
   logic             rd_q = 1'b0;
   logic             crd_q = 1'b0;
   logic [7:0]       reg_q[$];
   logic [7:0]       cpu_q[$];
   logic [31:0]      seed = 32'h0000009D;
   logic [EP_AW-1:0] a;
   logic [7:0]       d;
   int               fail_count = 0;
   int               n_tests = 0;

   always #12.5 clk = ~clk;

   eprom_byte_program_control #(.PULSE_CYC(PCYC)) eprom_byte_program_control_i
   (
      .sys_clk_in      (clk),
      .sys_rst_in      (rst),
      .reg_addr_in     (r_addr),
      .reg_wdata_in    (r_wdata),
      .reg_wr_in       (r_wr),
      .reg_rd_in       (r_rd),
      .reg_rdata_out   (r_rdata),
      .cpu_addr_in     (c_addr),
      .cpu_wdata_in    (c_wdata),
      .cpu_wr_in       (c_wr),
      .cpu_rd_in       (c_rd),
      .cpu_rdata_out   (c_rdata),
      .array_addr_out  (a_addr),
      .array_wdata_out (a_wdata),
      .array_rd_en_out (a_rd_en),
      .array_rdata_in  (a_rdata),
      .vpp_en_out      (vpp)
   );

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task chk_data(input string w, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask

   task chk_pin(input string w, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask

   task wrap_up();
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // *****
   // Bus tasks, entered just after a rising edge
   // *****
   task strobes(input logic [3:0] s);
      {r_wr, r_rd, c_wr, c_rd} <= s;
   endtask

   task peek();
      strobes(4'h0);
      @(negedge clk);
   endtask

   task reg_wr(input logic [7:0] ad, input logic [7:0] wd);
      strobes(4'h8);
      r_addr <= ad;
      r_wdata <= wd;
      @(posedge clk);
   endtask

   task reg_rd(input logic [7:0] ad, input logic [7:0] e);
      strobes(4'h4);
      r_addr <= ad;
      reg_q.push_back(e);
      @(posedge clk);
   endtask

   task cpu_wr(input logic [EP_AW-1:0] ad, input logic [7:0] wd);
      strobes(4'h2);
      c_addr <= ad;
      c_wdata <= wd;
      @(posedge clk);
   endtask

   // Blocked reads must neither enable the array nor return its data
   task cpu_rd(input logic [EP_AW-1:0] ad, input logic [7:0] ad_data, input logic blk);
      strobes(4'h1);
      c_addr <= ad;
      a_rdata <= ad_data;
      cpu_q.push_back(blk ? 8'h00 : ad_data);
      @(negedge clk);
      chk_pin("array_rd_en", {15'h0000, !blk}, {15'h0000, a_rd_en});
      if (!blk)
         chk_pin("array_addr", 16'(ad), 16'(a_addr));
      @(posedge clk);
   endtask

   // *****
   // Result monitor and sequence
   // *****
   always @(posedge clk)
   begin
      rd_q <= r_rd;
      crd_q <= c_rd;
   end

   always @(negedge clk)
   begin
      if (rd_q === 1'b1)
         chk_data("reg_rdata", reg_q.size() ? reg_q.pop_front() : 8'hXX, r_rdata);
      if (crd_q === 1'b1)
         chk_data("cpu_rdata", cpu_q.size() ? cpu_q.pop_front() : 8'hXX, c_rdata);
   end

   initial
   begin
      #50000;
      fail_count++;
      wrap_up();
   end

   initial
   begin
      rst = 1'b1;
      strobes(4'h0);
      r_addr <= 8'h00;
      r_wdata <= 8'h00;
      c_addr <= '0;
      c_wdata <= 8'h00;
      a_rdata <= 8'h00;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_rd(CTRL_OFS, CTRL_RST);
      reg_rd(8'h05, 8'h00);
      reg_wr(CTRL_OFS, VPP);
      reg_rd(CTRL_OFS, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         a = EP_AW'(xs());
         d = 8'(xs());
         cpu_rd(a, d, 1'b0);
      end
      reg_wr(CTRL_OFS, LAT | VPP);
      reg_rd(CTRL_OFS, LAT);
      cpu_rd(a, d, 1'b1);
      a = EP_AW'(xs());
      d = 8'(xs());
      cpu_wr(a, d);
      cpu_wr(~a, ~d);
      peek();
      chk_pin("array_addr", 16'(a), 16'(a_addr));
      chk_pin("array_wdata", 16'(d), 16'(a_wdata));
      chk_pin("vpp", 16'h0000, 16'(vpp));
      @(posedge clk);
      reg_wr(CTRL_OFS, LAT | VPP);
      peek();
      chk_pin("vpp", 16'h0001, 16'(vpp));
      @(posedge clk);
      reg_rd(CTRL_OFS, LAT | VPP);
      strobes(4'h0);
      repeat (PCYC + 2) @(posedge clk);
      reg_rd(STAT_OFS, STAT);
      reg_wr(CTRL_OFS, LAT);
      peek();
      chk_pin("vpp", 16'h0000, 16'(vpp));
      @(posedge clk);
      reg_wr(CTRL_OFS, 8'h00);
      // Software keeps the unused bits at zero; only the two live bits vary
      for (int i = 0; i < 3; i++)
      begin
         d = 8'(xs()) & (LAT | VPP);
         reg_wr(CTRL_OFS, 8'h00);
         reg_wr(CTRL_OFS, d);
         reg_rd(CTRL_OFS, d & LAT);
      end
      reg_rd(STAT_OFS, 8'h00);
      reg_wr(CTRL_OFS, 8'h00);
      cpu_rd(a, 8'(xs()), 1'b0);
      strobes(4'h0);
      repeat (3) @(posedge clk);
      wrap_up();
   end
endmodule

`default_nettype wire
